// ===== rtl/dcd_defines.svh
// constants, opcodes and field positions of the dual-cpu decode block
// Function
// - one init pin starts both cpus together; each takes its own start vector
// - each cpu has its own nonmaskable pin; vectors FFFA for A, FFF2 for B
// - rise_edge_input rising, fall_edge_input falling, low level request low level
// - timer expiry, other-cpu request and host events raise maskable requests
// - every source sets a status flag; per-cpu enables gate the request
// - a cpu ignores maskable requests while its mask flag is one
// - opcodes latch per cpu; one shared decoder makes that cpu's controls
// - multiply gives unsigned Y times A in 10 clocks; high in A, low in Y
// - bit force ops are zero page, five cycles, set or clear one bit
// - bit test branch: bit index from opcode, address byte two, offset byte three
// - bit test branch takes five, six same page, seven other page
// - set variant branches on one, clear variant on zero, else falls through
// - push index takes three cycles, pull index takes four
// - unconditional branch takes three cycles same page, four other page
// - decimal add and subtract take one cycle more than binary
// - init clears each cpu's decimal flag
// - indirect jump pointer high byte fetch carries into the page
// - carry follows bit eight carry out; set and clear carry ops force it
// - zero flag set when all eight result bits are zero, else cleared
// - mask flag set on init, on maskable and on own nonmaskable entry
// - unmask clears, mask and trap set; return and pull flags reload it
// - servicing one cpu leaves the other alone unless it enables that source
// - shared decoder serves the two cpus on alternating clocks
// - after init A loads start vector FFFC, B loads FFF4
`ifndef DCD_DEFINES_SVH
`define DCD_DEFINES_SVH
`define DCD_OP_MUL    8'h02
`define DCD_OP_BRA    8'h80
`define DCD_OP_PHX    8'hDA
`define DCD_OP_PHY    8'h5A
`define DCD_OP_PLX    8'hFA
`define DCD_OP_PLY    8'h7A
`define DCD_OP_SEC    8'h38
`define DCD_OP_CLC    8'h18
`define DCD_OP_SEI    8'h78
`define DCD_OP_CLI    8'h58
`define DCD_OP_SED    8'hF8
`define DCD_OP_CLD    8'hD8
`define DCD_OP_CLV    8'hB8
`define DCD_OP_BRK    8'h00
`define DCD_OP_PLP    8'h28
`define DCD_OP_RTI    8'h40
`define DCD_LO_BITF   4'h7
`define DCD_LO_BBX    4'hF
`define DCD_CC_ALU    2'h1
`define DCD_AAA_ADC   3'h3
`define DCD_AAA_SBC   3'h7
`define DCD_OP_LO     3:0
`define DCD_OP_BIT    6:4
`define DCD_OP_POL    7
`define DCD_OP_CC     1:0
`define DCD_OP_AAA    7:5
`define DCD_CYC_MUL   4'hA
`define DCD_CYC_BITF  4'h5
`define DCD_CYC_BBX   4'h5
`define DCD_CYC_BRA   4'h3
`define DCD_CYC_PUSH  4'h3
`define DCD_CYC_PULL  4'h4
`define DCD_CYC_MIN   4'h2
`define DCD_CNT_FIRST 4'h1
`define DCD_VEC_A_INI 16'hFFFC
`define DCD_VEC_A_NMI 16'hFFFA
`define DCD_VEC_A_IRQ 16'hFFFE
`define DCD_VEC_B_INI 16'hFFF4
`define DCD_VEC_B_NMI 16'hFFF2
`define DCD_VEC_B_IRQ 16'hFFF6
`define DCD_F_C       0
`define DCD_F_Z       1
`define DCD_F_I       2
`define DCD_F_D       3
`define DCD_F_V       6
`define DCD_F_N       7
`define DCD_EV_RISE   0
`define DCD_EV_LVL    2
`define DCD_REG_EVT   8'h00
`define DCD_REG_ENA   8'h04
`define DCD_REG_ENB   8'h08
`define DCD_REG_PSA   8'h0C
`define DCD_REG_PSB   8'h10
`endif

// ===== rtl/dcd_pkg.sv
// types shared by the dual-cpu decode block
package dcd_pkg;
   typedef enum logic [1:0] {DCD_IDLE, DCD_EXEC, DCD_INTS} dcd_mode_t;
   typedef enum logic [1:0] {DCD_K_INIT, DCD_K_NMI, DCD_K_IRQ} dcd_kind_t;
   typedef struct packed {
      logic                  slot;
      logic [1:0]            busy;
      dcd_mode_t [1:0]       mode;
      dcd_kind_t [1:0]       kind;
      logic [1:0][7:0]       ir;
      logic [1:0][7:0]       opnd;
      logic [1:0][3:0]       cnt;
      logic [1:0][3:0]       len;
      logic [1:0]            tk;
      logic [1:0][15:0]      prod;
      logic [1:0][7:0]       ps;
      logic [1:0]            nmi_prev;
      logic [1:0]            nmi_pend;
      logic                  rise_prev;
      logic                  fall_prev;
      logic [7:0]            ev;
      logic [1:0][7:0]       en;
      logic [1:0]            irq;
      logic                  done;
      logic                  done_cpu;
      logic                  taken;
      logic                  vec_req;
      logic                  vec_cpu;
      logic [15:0]           vec_addr;
      logic                  pvld;
      logic [15:0]           product;
      logic                  bwr;
      logic [7:0]            bdata;
      logic [15:0]           ind_hi;
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
   } dcd_state_t;
endpackage

// ===== rtl/dcd_core.sv
// shared decoder, interrupt sequencer and status flags of two 8-bit cpus
`timescale 1ns/1ps
`include "dcd_defines.svh"
module dcd_core #(
   parameter int INT_CYCLES = 7
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        common_init_pin_n,
   input  wire logic        cpu_a_nonmaskable_pin_n,
   input  wire logic        cpu_b_nonmaskable_pin_n,
   input  wire logic        rise_edge_input,
   input  wire logic        fall_edge_input,
   input  wire logic        low_level_request_input_n,
   input  wire logic        timer_a_expire,
   input  wire logic        timer_b_expire,
   input  wire logic        host_event,
   input  wire logic        ipc_req_to_a,
   input  wire logic        ipc_req_to_b,
   input  wire logic        opcode_load,
   input  wire logic [7:0]  opcode_in,
   input  wire logic [7:0]  bus_data,
   input  wire logic        page_cross,
   input  wire logic [3:0]  legacy_cycles,
   input  wire logic [7:0]  reg_a_in,
   input  wire logic [7:0]  reg_y_in,
   input  wire logic [15:0] ind_ptr,
   input  wire logic        alu_valid,
   input  wire logic [7:0]  alu_result,
   input  wire logic        alu_carry_valid,
   input  wire logic        alu_carry,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             active_cpu,
   output logic [1:0]       busy,
   output logic [1:0]       irq_req,
   output logic             instr_done,
   output logic             done_cpu,
   output logic             branch_taken,
   output logic             vec_req,
   output logic             vec_cpu,
   output logic [15:0]      vec_addr,
   output logic             product_valid,
   output logic [15:0]      product,
   output logic             bit_write,
   output logic [7:0]       bit_write_data,
   output logic [15:0]      ptr_hi_addr,
   output logic [7:0]       flags_a,
   output logic [7:0]       flags_b,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   localparam logic [3:0] INT_CYC = 4'(INT_CYCLES);

   dcd_pkg::dcd_state_t st_q;
   dcd_pkg::dcd_state_t st_d;

   // the counter is four bits wide, so a longer entry cannot be served
   generate
      if (INT_CYCLES < 2 || INT_CYCLES > 15)
      begin : g_chk
         $error("INT_CYCLES must lie in 2..15");
      end
   endgenerate

   // branch decision of the bit test and always branches
   function automatic logic f_tk(input logic [7:0] op, input logic [7:0] d);
      logic hit;
      hit = 1'b0;
      if (op[`DCD_OP_LO] == `DCD_LO_BBX)
         hit = (d[op[`DCD_OP_BIT]] == op[`DCD_OP_POL]);
      else if (op == `DCD_OP_BRA)
         hit = 1'b1;
      return hit;
   endfunction

   // instruction length in the cpu's own clocks
   function automatic logic [3:0] f_len(input logic [7:0] op,
                                        input logic       dec,
                                        input logic       tk,
                                        input logic       pc,
                                        input logic [3:0] leg);
      logic [3:0] n;
      n = (leg < `DCD_CYC_MIN) ? `DCD_CYC_MIN : leg;
      if (op == `DCD_OP_MUL)
         n = `DCD_CYC_MUL;
      else if (op[`DCD_OP_LO] == `DCD_LO_BITF)
         n = `DCD_CYC_BITF;
      else if (op[`DCD_OP_LO] == `DCD_LO_BBX)
         n = `DCD_CYC_BBX + {3'h0, tk} + {3'h0, tk & pc};
      else if (op == `DCD_OP_BRA)
         n = `DCD_CYC_BRA + {3'h0, pc};
      else if (op == `DCD_OP_PHX || op == `DCD_OP_PHY)
         n = `DCD_CYC_PUSH;
      else if (op == `DCD_OP_PLX || op == `DCD_OP_PLY)
         n = `DCD_CYC_PULL;
      else if (dec && op[`DCD_OP_CC] == `DCD_CC_ALU &&
               (op[`DCD_OP_AAA] == `DCD_AAA_ADC || op[`DCD_OP_AAA] == `DCD_AAA_SBC))
         n = n + `DCD_CYC_MIN - 4'h1;
      return n;
   endfunction

   // handler address per cpu and entry kind
   function automatic logic [15:0] f_vec(input logic cpu, input dcd_pkg::dcd_kind_t k);
      logic [15:0] v;
      case (k)
         dcd_pkg::DCD_K_NMI: v = cpu ? `DCD_VEC_B_NMI : `DCD_VEC_A_NMI;
         dcd_pkg::DCD_K_IRQ: v = cpu ? `DCD_VEC_B_IRQ : `DCD_VEC_A_IRQ;
         default:            v = cpu ? `DCD_VEC_B_INI : `DCD_VEC_A_INI;
      endcase
      return v;
   endfunction

   // next state: one cpu slot per clock, then alu, pins, init and bus
   always_comb
   begin
      logic       c;
      logic       rq;
      logic       acc;
      logic       hit;
      logic [1:0] nmi_n;
      logic [7:0] evs;
      logic [7:0] op;
      logic [31:0] rd;
      c     = st_q.slot;
      rq    = 1'b0;
      acc   = psel & penable;
      hit   = 1'b1;
      nmi_n = {cpu_b_nonmaskable_pin_n, cpu_a_nonmaskable_pin_n};
      evs   = 8'h00;
      op    = st_q.ir[st_q.slot];
      rd    = 32'h0000_0000;
      st_d  = st_q;
      st_d.done    = 1'b0;
      st_d.vec_req = 1'b0;
      st_d.pvld    = 1'b0;
      st_d.taken   = 1'b0;
      st_d.bwr     = 1'b0;
      st_d.slot    = ~st_q.slot;

      // the decoder serves only the cpu that owns this clock
      rq = (|(st_q.ev & st_q.en[c])) & ~st_q.ps[c][`DCD_F_I];
      case (st_q.mode[c])
         dcd_pkg::DCD_IDLE:
         begin
            if (st_q.nmi_pend[c] || rq)
            begin
               st_d.mode[c] = dcd_pkg::DCD_INTS;
               st_d.kind[c] = st_q.nmi_pend[c] ? dcd_pkg::DCD_K_NMI : dcd_pkg::DCD_K_IRQ;
               st_d.cnt[c]  = `DCD_CNT_FIRST;
               st_d.nmi_pend[c] = 1'b0;
               st_d.ps[c][`DCD_F_I] = 1'b1;
            end
            else if (opcode_load)
            begin
               st_d.mode[c] = dcd_pkg::DCD_EXEC;
               st_d.ir[c]   = opcode_in;
               st_d.opnd[c] = bus_data;
               st_d.tk[c]   = f_tk(opcode_in, bus_data);
               st_d.len[c]  = f_len(opcode_in, st_q.ps[c][`DCD_F_D],
                                    f_tk(opcode_in, bus_data), page_cross,
                                    legacy_cycles);
               st_d.cnt[c]  = `DCD_CNT_FIRST;
               st_d.prod[c] = {8'h00, reg_a_in} * {8'h00, reg_y_in};
               st_d.ind_hi  = ind_ptr + 16'h0001;
            end
         end
         dcd_pkg::DCD_EXEC:
         begin
            if (st_q.cnt[c] + 4'h1 == st_q.len[c])
            begin
               st_d.mode[c]  = dcd_pkg::DCD_IDLE;
               st_d.done     = 1'b1;
               st_d.done_cpu = c;
               st_d.taken    = st_q.tk[c];
               case (op)
                  `DCD_OP_SEC: st_d.ps[c][`DCD_F_C] = 1'b1;
                  `DCD_OP_CLC: st_d.ps[c][`DCD_F_C] = 1'b0;
                  `DCD_OP_SEI: st_d.ps[c][`DCD_F_I] = 1'b1;
                  `DCD_OP_CLI: st_d.ps[c][`DCD_F_I] = 1'b0;
                  `DCD_OP_SED: st_d.ps[c][`DCD_F_D] = 1'b1;
                  `DCD_OP_CLD: st_d.ps[c][`DCD_F_D] = 1'b0;
                  `DCD_OP_CLV: st_d.ps[c][`DCD_F_V] = 1'b0;
                  `DCD_OP_PLP: st_d.ps[c] = st_q.opnd[c];
                  `DCD_OP_RTI: st_d.ps[c] = st_q.opnd[c];
                  `DCD_OP_BRK:
                  begin
                     st_d.ps[c][`DCD_F_I] = 1'b1;
                     st_d.vec_req  = 1'b1;
                     st_d.vec_cpu  = c;
                     st_d.vec_addr = f_vec(c, dcd_pkg::DCD_K_IRQ);
                  end
                  `DCD_OP_MUL:
                  begin
                     st_d.pvld    = 1'b1;
                     st_d.product = st_q.prod[c];
                  end
                  default:
                  begin
                     // bit force writes back the operand with one bit changed
                     if (op[`DCD_OP_LO] == `DCD_LO_BITF)
                     begin
                        st_d.bwr   = 1'b1;
                        st_d.bdata = st_q.opnd[c];
                        st_d.bdata[op[`DCD_OP_BIT]] = op[`DCD_OP_POL];
                     end
                  end
               endcase
            end
            else
               st_d.cnt[c] = st_q.cnt[c] + 4'h1;
         end
         dcd_pkg::DCD_INTS:
         begin
            if (st_q.cnt[c] + 4'h1 == INT_CYC)
            begin
               st_d.mode[c]  = dcd_pkg::DCD_IDLE;
               st_d.vec_req  = 1'b1;
               st_d.vec_cpu  = c;
               st_d.vec_addr = f_vec(c, st_q.kind[c]);
            end
            else
               st_d.cnt[c] = st_q.cnt[c] + 4'h1;
         end
         default: st_d.mode[c] = dcd_pkg::DCD_IDLE;
      endcase

      // alu results land in the flags of the cpu owning this clock
      if (alu_valid)
      begin
         st_d.ps[c][`DCD_F_Z] = (alu_result == 8'h00);
         st_d.ps[c][`DCD_F_N] = alu_result[`DCD_F_N];
         if (alu_carry_valid)
            st_d.ps[c][`DCD_F_C] = alu_carry;
      end

      // pin edges; a new nonmaskable edge wins over the take above
      for (int i = 0; i < 2; i++)
      begin
         st_d.nmi_prev[i] = nmi_n[i];
         if (st_q.nmi_prev[i] && !nmi_n[i])
            st_d.nmi_pend[i] = 1'b1;
      end
      st_d.rise_prev = rise_edge_input;
      st_d.fall_prev = fall_edge_input;
      evs = {ipc_req_to_b, ipc_req_to_a, host_event, timer_b_expire, timer_a_expire,
             1'b0, st_q.fall_prev & ~fall_edge_input,
             rise_edge_input & ~st_q.rise_prev};

      // both cpus held in their entry sequence while the init pin is low
      if (!common_init_pin_n)
      begin
         for (int i = 0; i < 2; i++)
         begin
            st_d.mode[i] = dcd_pkg::DCD_INTS;
            st_d.kind[i] = dcd_pkg::DCD_K_INIT;
            st_d.cnt[i]  = `DCD_CNT_FIRST;
            st_d.nmi_pend[i] = 1'b0;
            st_d.ps[i][`DCD_F_I] = 1'b1;
            st_d.ps[i][`DCD_F_D] = 1'b0;
         end
      end

      // apb: one wait state, then the access completes
      case (paddr)
         `DCD_REG_EVT: rd = {24'h000000, st_q.ev};
         `DCD_REG_ENA: rd = {24'h000000, st_q.en[0]};
         `DCD_REG_ENB: rd = {24'h000000, st_q.en[1]};
         `DCD_REG_PSA: rd = {24'h000000, st_q.ps[0]};
         `DCD_REG_PSB: rd = {24'h000000, st_q.ps[1]};
         default:      hit = 1'b0;
      endcase
      st_d.pready  = acc & ~st_q.pready;
      st_d.pslverr = acc & ~st_q.pready & ~hit;
      if (acc && !st_q.pready)
         st_d.prdata = rd;
      if (acc && st_q.pready && pwrite)
      begin
         if (paddr == `DCD_REG_EVT)
            st_d.ev = st_q.ev & ~pwdata[7:0];
         if (paddr == `DCD_REG_ENA)
            st_d.en[0] = pwdata[7:0];
         if (paddr == `DCD_REG_ENB)
            st_d.en[1] = pwdata[7:0];
      end
      // a source event outranks a software clear in the same clock
      st_d.ev = st_d.ev | evs;
      st_d.ev[`DCD_EV_LVL] = ~low_level_request_input_n;

      for (int i = 0; i < 2; i++)
      begin
         st_d.busy[i] = (st_d.mode[i] != dcd_pkg::DCD_IDLE);
         st_d.irq[i]  = (|(st_d.ev & st_d.en[i])) & ~st_d.ps[i][`DCD_F_I];
      end
   end

   // state register; clk_en low freezes everything, bus included
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q           <= '0;
         st_q.mode      <= '{dcd_pkg::DCD_INTS, dcd_pkg::DCD_INTS};
         st_q.busy      <= 2'b11;
         st_q.cnt       <= {`DCD_CNT_FIRST, `DCD_CNT_FIRST};
         st_q.ps        <= {8'h04, 8'h04};
         st_q.nmi_prev  <= 2'b11;
         st_q.rise_prev <= 1'b1;
      end
      else if (clk_en)
         st_q <= st_d;
   end

   // outputs straight from the state register
   assign active_cpu     = st_q.slot;
   assign busy           = st_q.busy;
   assign irq_req        = st_q.irq;
   assign instr_done     = st_q.done;
   assign done_cpu       = st_q.done_cpu;
   assign branch_taken   = st_q.taken;
   assign vec_req        = st_q.vec_req;
   assign vec_cpu        = st_q.vec_cpu;
   assign vec_addr       = st_q.vec_addr;
   assign product_valid  = st_q.pvld;
   assign product        = st_q.product;
   assign bit_write      = st_q.bwr;
   assign bit_write_data = st_q.bdata;
   assign ptr_hi_addr    = st_q.ind_hi;
   assign flags_a        = st_q.ps[0];
   assign flags_b        = st_q.ps[1];
   assign prdata         = st_q.prdata;
   assign pready         = st_q.pready;
   assign pslverr        = st_q.pslverr;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_init_low;
      clk_en && !common_init_pin_n;
   endsequence
   sequence s_init_held;
      st_q.busy == 2'b11 && st_q.ps[0][`DCD_F_I] && st_q.ps[1][`DCD_F_I]
      && !st_q.ps[0][`DCD_F_D] && !st_q.ps[1][`DCD_F_D];
   endsequence

   chk_init_both: assert property (s_init_low |=> s_init_held)
      else $error("init pin did not hold both cpus");
   chk_decimal_clear: assert property (s_init_low |=> s_init_held)
      else $error("init did not clear decimal flag");
   chk_vec_per_cpu: assert property (vec_req && vec_cpu |->
      vec_addr inside {`DCD_VEC_B_NMI, `DCD_VEC_B_INI, `DCD_VEC_B_IRQ})
      else $error("cpu b took a cpu a vector");
   chk_rise_detect: assert property (clk_en && rise_edge_input && !st_q.rise_prev
      |=> st_q.ev[`DCD_EV_RISE])
      else $error("rising edge not flagged");
   chk_event_wins: assert property (clk_en && timer_a_expire |=> st_q.ev[3])
      else $error("timer event lost");
   chk_mask_blocks: assert property (st_q.mode[0] == dcd_pkg::DCD_INTS
      && st_q.kind[0] == dcd_pkg::DCD_K_IRQ && st_q.cnt[0] == `DCD_CNT_FIRST
      && $changed(st_q.mode[0]) |-> !$past(st_q.ps[0][`DCD_F_I]))
      else $error("masked request was taken");
   chk_mul_len: assert property (st_q.mode[1] == dcd_pkg::DCD_EXEC
      && st_q.ir[1] == `DCD_OP_MUL |-> st_q.len[1] == `DCD_CYC_MUL)
      else $error("multiply length wrong");
   chk_bbx_len: assert property (st_q.mode[0] == dcd_pkg::DCD_EXEC
      && st_q.ir[0][`DCD_OP_LO] == `DCD_LO_BBX
      |-> st_q.len[0] == `DCD_CYC_BBX + {3'h0, st_q.tk[0]}
          || st_q.len[0] == `DCD_CYC_BBX + 4'h2)
      else $error("bit test branch length wrong");
   chk_zero_flag: assert property (clk_en && alu_valid && alu_result == 8'h00
      && common_init_pin_n |=> st_q.ps[$past(st_q.slot)][`DCD_F_Z])
      else $error("zero flag not set");
   chk_slot_toggle: assert property (presetn && clk_en |=> st_q.slot != $past(st_q.slot))
      else $error("slot did not alternate");
endmodule

// ===== tb/dcd_ext_model.sv
// partner model: init, nonmaskable, event and timer pins around the block
`timescale 1ns/1ps
module dcd_ext_model (
   input  wire logic  pclk,
   output logic [10:0] pins
);
   // *********************************
   // pin driver
   // *********************************
   // rest levels: active-low pins high, edge inputs quiet
   initial pins = 11'h706;
   // invert one pin for n clocks; changes land just after an edge
   task automatic flip(input int i, input int n);
      @(posedge pclk);
      pins <= pins ^ (11'h001 << i);
      repeat (n) @(posedge pclk);
      pins <= pins ^ (11'h001 << i);
   endtask
endmodule

// ===== tb/tb.sv
// self-checking testbench of the dual-cpu decode block
`timescale 1ns/1ps
`include "dcd_defines.svh"
`define CHK(nm, e, g) \
   begin \
      total_checks++; \
      if ((g) !== (e)) \
      begin \
         error_cnt++; \
         $display("mismatch %s exp %h got %h", nm, e, g); \
      end \
   end
module tb;
   // *********************************
   // signals and instances
   // *********************************
   logic        pclk, presetn, opcode_load, page_cross, alu_valid, alu_carry_valid;
   logic        alu_carry, psel, penable, pwrite, err;
   logic [7:0]  opcode_in, bus_data, reg_a_in, reg_y_in, alu_result, paddr;
   logic [3:0]  legacy_cycles;
   logic [15:0] ind_ptr, vec_addr, product, ptr_hi_addr, prod_seen;
   logic [31:0] pwdata, prdata, rd;
   logic        active_cpu, instr_done, done_cpu, branch_taken, vec_req, vec_cpu;
   logic        product_valid, bit_write, pready, pslverr;
   logic [1:0]  busy, irq_req;
   logic [7:0]  bit_write_data, flags_a, flags_b, bw_seen;
   logic [10:0] pins;
   int          error_cnt, total_checks, cyc;
   // outside pins come from the partner; the clock enable stays on
   dcd_core dut (.clk_en(1'b1), .common_init_pin_n(pins[10]),
      .cpu_a_nonmaskable_pin_n(pins[8]), .cpu_b_nonmaskable_pin_n(pins[9]),
      .rise_edge_input(pins[0]), .fall_edge_input(pins[1]),
      .low_level_request_input_n(pins[2]), .timer_a_expire(pins[3]),
      .timer_b_expire(pins[4]), .host_event(pins[5]), .ipc_req_to_a(pins[6]),
      .ipc_req_to_b(pins[7]), .*);
   dcd_ext_model ext (.pclk(pclk), .pins(pins));
   // clock and a hang guard well above the whole run
   always #25 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   // *********************************
   // tasks
   // *********************************
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // apb transfer held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wait_vec(input logic [15:0] a, input logic c);
      int n;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (vec_req !== 1'b1 && n < 100);
      `CHK("vec_req", 1'b1, vec_req)
      `CHK("vec_addr", a, vec_addr)
      `CHK("vec_cpu", c, vec_cpu)
   endtask
   // load one opcode in the cpu's own slot, count clocks to done
   task automatic run_op(input logic c, input logic [7:0] op, bd, input logic pc,
                         input int ln, input logic tk, input logic [7:0] fm, fv);
      int n;
      logic k;
      n = 0;
      k = 0;
      do @(posedge pclk); while (active_cpu === c || busy[c] !== 1'b0);
      opcode_load <= 1;
      opcode_in <= op;
      bus_data <= bd;
      page_cross <= pc;
      @(posedge pclk);
      opcode_load <= 0;
      do
      begin
         @(posedge pclk);
         n++;
         if (branch_taken === 1'b1)
            k = 1;
         if (product_valid === 1'b1)
            prod_seen = product;
         if (bit_write === 1'b1)
            bw_seen = bit_write_data;
      end
      while (instr_done !== 1'b1 && n < 40);
      @(posedge pclk);
      `CHK("cycles", 2 * ln - 1, n)
      `CHK("done_cpu", c, done_cpu)
      `CHK("taken", tk, k)
      `CHK("flags", fv, (c ? flags_b : flags_a) & fm)
   endtask
   // one flag update from the alu in a cpu A slot
   task automatic alu(input logic [7:0] r, input logic cy);
      do @(posedge pclk); while (active_cpu !== 1'b1);
      alu_valid <= 1;
      alu_result <= r;
      alu_carry_valid <= 1;
      alu_carry <= cy;
      @(posedge pclk);
      alu_valid <= 0;
      alu_carry_valid <= 0;
      repeat (2) @(posedge pclk);
      `CHK("zc", {r == 8'h00, cy}, flags_a[1:0])
   endtask
   // *********************************
   // main sequence
   // *********************************
   initial
   begin
      {pclk, presetn, error_cnt, total_checks, cyc} = '0;
      {opcode_load, page_cross, alu_valid, alu_carry_valid, alu_carry} = '0;
      {psel, penable, pwrite, opcode_in, bus_data, alu_result, paddr, pwdata} = '0;
      {legacy_cycles, reg_a_in, reg_y_in, ind_ptr} = {4'h2, 8'hC8, 8'hFB, 16'h12FF};
      repeat (5) @(posedge pclk);
      presetn <= 1;
      wait_vec(16'hFFFC, 0);
      wait_vec(16'hFFF4, 1);
      `CHK("init_flags", 8'h04, flags_a & 8'h0C)
      run_op(0, `DCD_OP_CLI, 0, 0, 2, 0, 8'h04, 0);
      run_op(0, `DCD_OP_SEC, 0, 0, 2, 0, 1, 1);
      run_op(0, `DCD_OP_CLC, 0, 0, 2, 0, 1, 0);
      run_op(1, `DCD_OP_MUL, 0, 0, 10, 0, 0, 0);
      `CHK("product", 16'hC418, prod_seen)
      run_op(0, `DCD_OP_PHX, 0, 0, 3, 0, 0, 0);
      run_op(1, `DCD_OP_PLY, 0, 0, 4, 0, 0, 0);
      run_op(0, `DCD_OP_BRA, 0, 0, 3, 1, 0, 0);
      run_op(0, `DCD_OP_BRA, 0, 1, 4, 1, 0, 0);
      run_op(0, 8'hA7, 0, 0, 5, 0, 0, 0);
      `CHK("bit_data", 8'h04, bw_seen)
      run_op(1, 8'h67, 8'hFF, 0, 5, 0, 0, 0);
      `CHK("bit_data", 8'hBF, bw_seen)
      run_op(0, 8'h3F, 8'hF7, 1, 7, 1, 0, 0);
      run_op(1, 8'hDF, 8'h20, 0, 6, 1, 0, 0);
      run_op(0, 8'hDF, 8'h00, 0, 5, 0, 0, 0);
      run_op(0, `DCD_OP_SED, 0, 0, 2, 0, 8'h08, 8'h08);
      run_op(0, 8'h69, 0, 0, 3, 0, 0, 0);
      run_op(0, `DCD_OP_CLD, 0, 0, 2, 0, 8'h08, 0);
      run_op(0, 8'hE9, 0, 0, 2, 0, 0, 0);
      run_op(1, `DCD_OP_PLP, 8'hC3, 0, 2, 0, 8'hCF, 8'hC3);
      `CHK("ptr_hi", 16'h1300, ptr_hi_addr)
      alu(8'h00, 1);
      alu(8'h55, 0);
      // every event source but the low level request sets its flag; nothing enabled, so no request
      for (int i = 0; i < 8; i++)
         if (i != 2)
         begin
            ext.flip(i, 1);
            apb(0, `DCD_REG_EVT, 0);
            `CHK("event", 1'b1, rd[i])
            `CHK("irq", 2'b00, irq_req)
            apb(1, `DCD_REG_EVT, 32'h1 << i);
         end
      apb(0, 8'h40, 0);
      `CHK("slverr", 1'b1, err)
      `CHK("rdata", 32'h0, rd)
      apb(1, `DCD_REG_ENA, 32'h4);
      fork
         ext.flip(2, 40);
         begin
            // the request must show before cpu A takes it and masks itself
            do @(posedge pclk); while (irq_req[0] !== 1'b1);
            `CHK("irq_a", 1'b1, irq_req[0])
            wait_vec(`DCD_VEC_A_IRQ, 0);
            repeat (2) @(posedge pclk);
            `CHK("irq_masked", 2'b00, irq_req)
            `CHK("mask_a", 1'b1, flags_a[2])
         end
      join
      apb(1, `DCD_REG_ENA, 0);
      ext.flip(9, 2);
      wait_vec(16'hFFF2, 1);
      `CHK("mask_b", 1'b1, flags_b[2])
      run_op(1, `DCD_OP_SEI, 0, 0, 2, 0, 8'h04, 8'h04);
      run_op(0, `DCD_OP_SED, 0, 0, 2, 0, 8'h08, 8'h08);
      // start the init pulse so that cpu A owns the first counting clock
      do @(posedge pclk); while (active_cpu !== 1'b1);
      ext.flip(10, 3);
      `CHK("busy", 2'b11, busy)
      `CHK("init_d", 8'h04, flags_a & 8'h0C)
      wait_vec(16'hFFFC, 0);
      wait_vec(16'hFFF4, 1);
      print_verdict();
   end
endmodule
